/* src/scs_regs.vh */
// Purpose: Constants for the switching clock and sync mode block
// Assumes: 10 MHz system clock
// Notes:   Frequencies in kHz; periods in system clock cycles
`ifndef SCS_REGS_VH
`define SCS_REGS_VH
`define SCS_CLK_KHZ        14'd10000
`define SCS_MODE_STANDALONE 16'h0000
`define SCS_MODE_MASTER    16'h0100
`define SCS_MODE_SLAVE_IN  16'h0120
`define SCS_MODE_SLAVE_OUT 16'h0121
`define SCS_STEP_KHZ       11'd50
`define SCS_FREQ_MIN_KHZ   11'd300
`define SCS_FREQ_MAX_KHZ   11'd1500
`define SCS_SYNC_TIMEOUT_US 16'd10
`define SCS_SYNC_TIMEOUT   16'd100
`define SCS_CODE_W         4
`define SCS_PER_W          6
`endif

/* src/scs_switch_clock.v */
// Purpose: Switching clock generation and sync mode control
// Assumes: Resistor code arrives digitised with a valid strobe during power-up
// Notes:   Periods are whole system cycles, so frequencies are approximate
`timescale 1ns/1ns
`default_nettype none
`include "scs_regs.vh"

// What this block does
// - Fifteen resistor codes map 300 to 1500 kHz
// - Resistor code latched once at power-up
// - Override frequency writes in 50 kHz steps
// - Four modes, master by default
// - Mode values 0000, 0100, 0120, 0121 select mode
// - Standalone releases the pin after power-up
// - Master drives 50 percent wave, one system cycle behind the switching node
// - Slave in phase locks to external clock
// - Slave out of phase switches half period away
// - No external clock means own frequency
module scs_switch_clock (
	// Clock and reset
	input  wire        clk_sys,
	input  wire        rst_n,
	// Power-up resistor measurement
	input  wire [3:0]  rate_set_resistor,
	input  wire        rate_set_valid,
	input  wire        power_up_done,
	// Command side
	input  wire        freq_override_we,
	input  wire [4:0]  freq_override_steps,
	input  wire        phase_mode_command_we,
	input  wire [15:0] phase_mode_command,
	// Rate/sync pin
	input  wire        rate_sync_pin_in,
	output reg         rate_sync_pin_out,
	output reg         rate_sync_pin_oe,
	output reg         rate_sync_pin_inject,
	// Switching clock and status
	output reg         switch_node,
	output reg         sync_locked,
	output reg  [15:0] mode_reg_out
);

	// Mode encodings held internally
	localparam MODE_STAND = 2'b00;
	localparam MODE_MASTER = 2'b01;
	localparam MODE_SL_IN = 2'b10;
	localparam MODE_SL_OUT = 2'b11;

	// Resistor code to frequency in kHz
	function [10:0] code_to_khz;
		input [3:0] code;
		begin
			case (code)
			4'h0: code_to_khz = `SCS_FREQ_MIN_KHZ;
			4'h1: code_to_khz = 11'd400;
			4'h2: code_to_khz = 11'd500;
			4'h3: code_to_khz = 11'd550;
			4'h4: code_to_khz = 11'd600;
			4'h5: code_to_khz = 11'd650;
			4'h6: code_to_khz = 11'd700;
			4'h7: code_to_khz = 11'd750;
			4'h8: code_to_khz = 11'd800;
			4'h9: code_to_khz = 11'd850;
			4'hA: code_to_khz = 11'd900;
			4'hB: code_to_khz = 11'd950;
			4'hC: code_to_khz = 11'd1000;
			4'hD: code_to_khz = 11'd1250;
			default: code_to_khz = `SCS_FREQ_MAX_KHZ;
			endcase
		end
	endfunction

	// Half period in system cycles for a frequency in kHz
	function [`SCS_PER_W-1:0] khz_to_half;
		input [10:0] khz;
		reg   [13:0] full;
		begin
			full = `SCS_CLK_KHZ / {3'h0, khz};
			khz_to_half = full[`SCS_PER_W:1];
		end
	endfunction

	reg        sync_m_reg;
	reg        sync_s_reg;
	reg        sync_d_reg;
	reg        latched_reg;
	reg [10:0] freq_khz_reg;
	reg [1:0]  mode_reg;
	reg [15:0] timeout_reg;
	reg [`SCS_PER_W-1:0] own_half_reg;
	reg [`SCS_PER_W-1:0] ext_half_reg;
	reg [`SCS_PER_W:0]   ext_cnt_reg;
	reg [`SCS_PER_W-1:0] phase_cnt_reg;
	reg        ext_ok_reg;
	reg        power_done_reg;
	reg        edge_seen_reg;

	wire       ext_rise = sync_s_reg & ~sync_d_reg;
	wire       slave = mode_reg[1];
	wire       follow = slave & ext_ok_reg;
	wire [`SCS_PER_W-1:0] half = follow ? ext_half_reg : own_half_reg;
	wire [11:0] ovr_khz = {7'h00, freq_override_steps} * {1'b0, `SCS_STEP_KHZ};
	// The counter holds the cycles between edges minus one, so one is added back
	wire [`SCS_PER_W+1:0] ext_period = {1'b0, ext_cnt_reg} + {{(`SCS_PER_W+1){1'b0}}, 1'b1};

	// Pin is asynchronous to clk_sys, two stages before use
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sync_m_reg <= 1'b0;
			sync_s_reg <= 1'b0;
			sync_d_reg <= 1'b0;
		end else begin
			sync_m_reg <= rate_sync_pin_in;
			sync_s_reg <= sync_m_reg;
			sync_d_reg <= sync_s_reg;
		end
	end

	// Frequency source and mode
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			latched_reg <= 1'b0;
			freq_khz_reg <= `SCS_FREQ_MIN_KHZ;
			mode_reg <= MODE_MASTER;
			mode_reg_out <= `SCS_MODE_MASTER;
			power_done_reg <= 1'b0;
		end else begin
			power_done_reg <= power_up_done;
			// Measured once only, later strobes ignored
			if (rate_set_valid && !latched_reg && !power_done_reg) begin
				latched_reg <= 1'b1;
				freq_khz_reg <= code_to_khz(rate_set_resistor);
			end else if (freq_override_we && ovr_khz >= {1'b0, `SCS_FREQ_MIN_KHZ}
				&& ovr_khz <= {1'b0, `SCS_FREQ_MAX_KHZ}) begin
				freq_khz_reg <= ovr_khz[10:0];
			end
			if (phase_mode_command_we) begin
				case (phase_mode_command)
				`SCS_MODE_STANDALONE: begin
					mode_reg <= MODE_STAND;
					mode_reg_out <= phase_mode_command;
				end
				`SCS_MODE_MASTER: begin
					mode_reg <= MODE_MASTER;
					mode_reg_out <= phase_mode_command;
				end
				`SCS_MODE_SLAVE_IN: begin
					mode_reg <= MODE_SL_IN;
					mode_reg_out <= phase_mode_command;
				end
				`SCS_MODE_SLAVE_OUT: begin
					mode_reg <= MODE_SL_OUT;
					mode_reg_out <= phase_mode_command;
				end
				default: begin
					mode_reg <= mode_reg;
				end
				endcase
			end
		end
	end

	// External clock detection and period measurement
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			own_half_reg <= {`SCS_PER_W{1'b1}};
			timeout_reg <= 16'h0000;
			ext_ok_reg <= 1'b0;
			ext_cnt_reg <= {(`SCS_PER_W+1){1'b0}};
			ext_half_reg <= {`SCS_PER_W{1'b1}};
			edge_seen_reg <= 1'b0;
		end else begin
			own_half_reg <= khz_to_half(freq_khz_reg);
			if (!power_done_reg || !slave) begin
				ext_ok_reg <= 1'b0;
				edge_seen_reg <= 1'b0;
				timeout_reg <= 16'h0000;
				ext_cnt_reg <= {(`SCS_PER_W+1){1'b0}};
			end else if (ext_rise) begin
				timeout_reg <= 16'h0000;
				ext_cnt_reg <= {(`SCS_PER_W+1){1'b0}};
				edge_seen_reg <= 1'b1;
				// Needs two edges so the measured period is real
				if (edge_seen_reg) begin
					ext_half_reg <= ext_period[`SCS_PER_W:1];
					ext_ok_reg <= 1'b1;
				end
			end else begin
				if (ext_cnt_reg != {(`SCS_PER_W+1){1'b1}})
					ext_cnt_reg <= ext_cnt_reg + 1'b1;
				// A stale first edge must not start a bogus period measurement
				if (timeout_reg >= `SCS_SYNC_TIMEOUT - 16'd1) begin
					ext_ok_reg <= 1'b0;
					edge_seen_reg <= 1'b0;
				end else
					timeout_reg <= timeout_reg + 16'd1;
			end
		end
	end

	// Switching clock: a counter over each half period
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			phase_cnt_reg <= {`SCS_PER_W{1'b0}};
			switch_node <= 1'b0;
			sync_locked <= 1'b0;
		end else begin
			sync_locked <= follow;
			if (follow && ext_rise) begin
				// Re-align on each external rising edge
				phase_cnt_reg <= {`SCS_PER_W{1'b0}};
				switch_node <= (mode_reg == MODE_SL_OUT) ? 1'b0 : 1'b1;
			end else if (phase_cnt_reg >= half - 1'b1) begin
				phase_cnt_reg <= {`SCS_PER_W{1'b0}};
				switch_node <= ~switch_node;
			end else begin
				phase_cnt_reg <= phase_cnt_reg + 1'b1;
			end
		end
	end

	// Pin drive
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rate_sync_pin_out <= 1'b0;
			rate_sync_pin_oe <= 1'b0;
			rate_sync_pin_inject <= 1'b1;
		end else begin
			rate_sync_pin_inject <= ~latched_reg & ~power_done_reg;
			rate_sync_pin_oe <= power_done_reg && (mode_reg == MODE_MASTER);
			// Registered copy of the switching node keeps the wave at 50 percent, one clk_sys cycle behind it
			rate_sync_pin_out <= power_done_reg && (mode_reg == MODE_MASTER) && switch_node;
		end
	end

endmodule
`default_nettype wire

/* verif/scs_sva.sv */
// Purpose: Port checks for scs_switch_clock
// Assumes: One clock domain, clk_sys
// Notes:   Bound to the design below
`timescale 1ns/1ns
`default_nettype none
module scs_sva (
	// Clock and reset
	input wire logic        clk_sys,
	input wire logic        rst_n,
	// Controls
	input wire logic        power_up_done,
	input wire logic        phase_mode_command_we,
	input wire logic [15:0] phase_mode_command,
	input wire logic        rate_sync_pin_in,
	// Outputs
	input wire logic        rate_sync_pin_out,
	input wire logic        rate_sync_pin_oe,
	input wire logic        rate_sync_pin_inject,
	input wire logic        switch_node,
	input wire logic        sync_locked,
	input wire logic [15:0] mode_reg_out
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	logic [7:0] quiet_reg;
	logic       known;
	assign known = phase_mode_command inside {16'h0000, 16'h0100, 16'h0120, 16'h0121};
	// Saturates so a long quiet pin cannot wrap back to zero
	always_ff @(posedge clk_sys or negedge rst_n)
		if (!rst_n)
			quiet_reg <= 8'h00;
		else
			quiet_reg <= $changed(rate_sync_pin_in) ? 8'h00 : quiet_reg + {7'h00, quiet_reg != 8'hFF};
	reset_mode_a: assert property ($rose(rst_n) |-> mode_reg_out == 16'h0100) else $error("bad reset mode");
	mode_take_a: assert property (phase_mode_command_we && known |=> mode_reg_out == $past(phase_mode_command))
		else $error("mode not taken");
	mode_keep_a: assert property (phase_mode_command_we && !known |=> $stable(mode_reg_out)) else $error("bad mode taken");
	pin_free_a: assert property ((power_up_done && mode_reg_out != 16'h0100)[*3] |-> !rate_sync_pin_oe)
		else $error("pin driven");
	master_wave_a: assert property ((power_up_done && mode_reg_out == 16'h0100)[*3]
		|-> rate_sync_pin_oe && rate_sync_pin_out == $past(switch_node)) else $error("bad master wave");
	inject_stop_a: assert property (power_up_done[*3] |-> !rate_sync_pin_inject) else $error("still injecting");
	lock_slave_a: assert property ($rose(sync_locked) |-> mode_reg_out[15:1] == 15'h0090) else $error("lock in bad mode");
	lock_drop_a: assert property (quiet_reg > 8'd110 |-> !sync_locked) else $error("lock without edges");
endmodule
bind scs_switch_clock scs_sva scs_sva_i (.clk_sys, .rst_n, .power_up_done, .phase_mode_command_we, .phase_mode_command,
	.rate_sync_pin_in, .rate_sync_pin_out, .rate_sync_pin_oe, .rate_sync_pin_inject, .switch_node, .sync_locked, .mode_reg_out);
`default_nettype wire

/* verif/scs_sync_partner.sv */
// Purpose: Far converter driving the sync clock
// Assumes: 800 ns period while enabled
// Notes:   Releases the pin between bursts
`timescale 1ns/1ns
`default_nettype none
module scs_sync_partner (
	// Control and pin
	input  wire logic en,
	output var  logic drive_oe,
	output var  logic clk_out
);
	initial begin
		drive_oe = 1'b0;
		clk_out = 1'b0;
		forever begin
			wait (en);
			#37 drive_oe = 1'b1;
			while (en) begin
				#400 clk_out = ~clk_out;
			end
			clk_out = 1'b0;
			drive_oe = 1'b0;
		end
	end
endmodule
`default_nettype wire

/* verif/testbench.sv */
// Purpose: Self-checking bench for scs_switch_clock
// Assumes: Pin pulled to ground when nobody drives
// Notes:   Seed fixed at 79
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin errors++; $display("ERROR %s exp %0d got %0d", n, e, a); end end
module testbench;
	logic        clk_sys = 1'b0, rst_n = 1'b0, rate_set_valid = 1'b0, power_up_done = 1'b0, en = 1'b0, sw;
	logic        freq_override_we = 1'b0, phase_mode_command_we = 1'b0;
	logic [3:0]  rate_set_resistor = 4'h0;
	logic [4:0]  freq_override_steps = 5'h00;
	logic [15:0] phase_mode_command = 16'h0000;
	logic [15:0] tbl[5] = '{16'h0100, 16'h0000, 16'h0122, 16'h0120, 16'h0121};
	wire         pin_out, pin_oe, inject, switch_node, sync_locked, p_oe, p_clk;
	wire  [15:0] mode_reg_out;
	wire         rate_sync_pin_in = pin_oe ? pin_out : (p_oe ? p_clk : 1'b0);
	int          errors = 0, check_count = 0, seed = 79, code, hi, k;
	always #50 clk_sys = ~clk_sys;
	scs_switch_clock scs_switch_clock_i (.clk_sys, .rst_n, .rate_set_resistor, .rate_set_valid, .power_up_done,
		.freq_override_we, .freq_override_steps, .phase_mode_command_we, .phase_mode_command, .rate_sync_pin_in,
		.rate_sync_pin_out(pin_out), .rate_sync_pin_oe(pin_oe), .rate_sync_pin_inject(inject), .switch_node,
		.sync_locked, .mode_reg_out);
	scs_sync_partner scs_sync_partner_i (.en, .drive_oe(p_oe), .clk_out(p_clk));
	function automatic int half(input int c);
		return (10000 / (c == 0 ? 300 : c == 1 ? 400 : c < 13 ? 400 + 50 * c : c == 13 ? 1250 : c == 14 ? 1500 : c)) / 2;
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic give_up;
		errors++;
		end_of_test();
	endtask
	task automatic measure;
		for (k = 0; k < 300 && switch_node !== 1'b0; k++) tick(1);
		if (k == 300) give_up();
		for (k = 0; k < 300 && switch_node !== 1'b1; k++) tick(1);
		if (k == 300) give_up();
		for (hi = 0; hi < 300 && switch_node === 1'b1; hi++) tick(1);
		if (hi == 300) give_up();
	endtask
	task automatic drive(input logic [15:0] v, input logic m);
		phase_mode_command = v;
		freq_override_steps = v[4:0];
		phase_mode_command_we = m;
		freq_override_we = !m;
		tick(1);
		phase_mode_command_we = 1'b0;
		freq_override_we = 1'b0;
		// An edge passes with the strobes low before the next call raises them
		tick(1);
	endtask
	task automatic phase(input logic e);
		for (k = 0; k < 20 && p_clk !== 1'b0; k++) tick(1);
		if (k == 20) give_up();
		for (k = 0; k < 20 && p_clk !== 1'b1; k++) tick(1);
		if (k == 20) give_up();
		tick(4);
		`CHK("phase", e, switch_node)
	endtask
	task automatic end_of_test;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		tick(12);
		rst_n = 1'b1;
		`CHK("mode", 16'h0100, mode_reg_out)
		`CHK("inject", 1'b1, inject)
		code = {$random(seed)} % 15;
		rate_set_resistor = 4'(code);
		rate_set_valid = 1'b1;
		tick(1);
		// A second strobe must not replace the first code
		rate_set_resistor = 4'((code + 1) % 15);
		tick(1);
		`CHK("inject", 1'b0, inject)
		power_up_done = 1'b1;
		tick(4);
		measure();
		`CHK("own", half(code), hi)
		$display("test power-up done");
		code = 6 + {$random(seed)} % 25;
		drive(16'(code), 1'b0);
		drive(16'h0005, 1'b0);
		measure();
		measure();
		`CHK("override", half(code * 50), hi)
		for (int i = 0; i < 5; i++) begin
			drive(tbl[i], 1'b1);
			`CHK("mode", i == 2 ? 16'h0000 : tbl[i], mode_reg_out)
		end
		en = 1'b1;
		tick(40);
		`CHK("locked", 1'b1, sync_locked)
		measure();
		`CHK("slave", 4, hi)
		phase(1'b0);
		drive(16'h0120, 1'b1);
		tick(40);
		phase(1'b1);
		en = 1'b0;
		tick(150);
		`CHK("unlocked", 1'b0, sync_locked)
		measure();
		measure();
		`CHK("fallback", half(code * 50), hi)
		drive(16'h0100, 1'b1);
		tick(3);
		`CHK("drive", 1'b1, pin_oe)
		sw = switch_node;
		tick(1);
		`CHK("wave", sw, pin_out)
		drive(16'h0000, 1'b1);
		tick(3);
		`CHK("release", 1'b0, pin_oe)
		$display("test modes done");
		end_of_test();
	end
endmodule
`default_nettype wire
